// ---- logic/pd_controller.sv ----
// Controller end: drives CKE, reset and commands with power-down timing
// Assumes user requests arrive synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module pd_controller #(
   parameter int PD_MAX = pd_ctrl_pkg::PDMAX_CYC   // Power-down limit, cycles
) (
   input  wire logic   sys_clk,
   input  wire logic   resetn,
   pd_link_if.ctl      link,
   input  wire logic   pdReq,        // Request power-down
   input  wire logic   busy,         // Burst, MRS, ZQ or DLL lock in progress
   input  wire logic   refReq,       // Request refresh
   input  wire logic   slowExit,     // Device in slow-exit mode
   input  wire logic   memReset,     // Assert memory reset
   output logic        pdActive,     // Link in power-down
   output logic        cmdReady,     // Any command allowed
   output logic        dllCmdReady   // DLL commands allowed
);
   import pd_ctrl_pkg::*;
   ctl_state_e state_ff;
   logic [CNT_W-1:0] cnt_ff;         // State timer
   logic [CNT_W-1:0] sinceExit_ff;   // Cycles from exit [R19]
   logic [CNT_W-1:0] sinceRef_ff;    // Cycles from refresh [R21]
   logic pdLong;
   assign pdLong = cnt_ff >= CNT_W'(PD_MAX - 1);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_ff <= CS_RUN;
      end else begin
         case (state_ff)
            CS_RUN: begin
               // Entry only when idle, re-entry and refresh windows met [R2] [R19] [R21]
               if (pdReq && !busy && !refReq && !memReset &&
                   sinceExit_ff >= CNT_W'(XPDLL_CYC) &&
                   sinceRef_ff >= CNT_W'(RFC_CYC)) begin
                  state_ff <= CS_DROP;
               end
            end
            CS_DROP: if (cnt_ff >= CNT_W'(CPDED_CYC)) state_ff <= CS_PD;   // [R7]
            CS_PD: begin
               // Hold tCKE, leave on request or limit [R14] [R15]
               if (cnt_ff >= CNT_W'(CKE_CYC) && (!pdReq || pdLong || memReset)) begin
                  state_ff <= CS_RAISE;
               end
            end
            CS_RAISE: if (cnt_ff >= CNT_W'(CKE_CYC - 1)) state_ff <= CS_WAIT; // [R16]
            CS_WAIT: begin
               // Exit latency, and tRFC after early entry [R17] [R20]
               if (cnt_ff >= CNT_W'(XP_CYC) && sinceRef_ff >= CNT_W'(RFC_CYC)) begin
                  state_ff <= CS_RUN;
               end
            end
            default: state_ff <= CS_RUN;
         endcase
      end
   end

   // Timers from clock period [R22]
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         cnt_ff <= '0;
      end else if ((state_ff == CS_RUN) ||
                   (state_ff == CS_DROP && cnt_ff >= CNT_W'(CPDED_CYC)) ||
                   (state_ff == CS_RAISE && cnt_ff >= CNT_W'(CKE_CYC - 1))) begin
         cnt_ff <= '0;
      end else if (state_ff == CS_PD && cnt_ff >= CNT_W'(CKE_CYC) &&
                   (!pdReq || pdLong || memReset)) begin
         cnt_ff <= '0;
      end else if (cnt_ff != '1) begin
         cnt_ff <= cnt_ff + CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn || state_ff == CS_RAISE) begin
         sinceExit_ff <= '0;                 // Counted from registered exit [R19]
      end else if (sinceExit_ff != '1) begin
         sinceExit_ff <= sinceExit_ff + CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         sinceRef_ff <= CNT_W'(RFC_CYC);
      end else if (link.cmd == CMD_REF) begin
         sinceRef_ff <= '0;
      end else if (sinceRef_ff != '1) begin
         sinceRef_ff <= sinceRef_ff + CNT_W'(1);
      end
   end

   // ----------------------------------------------------------------
   // Link drive, all registered
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         link.cke    <= 1'b0;
         link.resetN <= 1'b0;
         link.cmd    <= CMD_NOP;
         link.odt    <= 1'b0;
         pdActive    <= 1'b0;
         cmdReady    <= 1'b0;
         dllCmdReady <= 1'b0;
      end else begin
         link.resetN <= !memReset;            // High unless memReset, which drops it even in power-down [R12] [R13]
         link.odt    <= 1'b0;                 // Kept at valid level [R12]
         // CKE low from drop through power-down [R1] [R14]
         link.cke    <= !(state_ff == CS_DROP || state_ff == CS_PD);
         // Refresh only in run, after tXP has passed [R18] [R3]
         // No back-to-back refresh while the counter has not yet seen the first [R20]
         if (state_ff == CS_RUN && refReq && sinceExit_ff >= CNT_W'(XP_CYC) &&
             sinceRef_ff >= CNT_W'(RFC_CYC) && link.cmd != CMD_REF) begin
            link.cmd <= CMD_REF;
         end else begin
            link.cmd <= CMD_NOP;              // NOP around entry and exit [R7] [R20]
         end
         pdActive    <= (state_ff == CS_PD);
         cmdReady    <= (state_ff == CS_RUN);
         // DLL commands wait tXPDLL on slow exit [R10] [R9] [R4]
         dllCmdReady <= (state_ff == CS_RUN) &&
                        (!slowExit || sinceExit_ff >= CNT_W'(XPDLL_CYC));
      end
   end
endmodule // pd_controller
`default_nettype wire

// ---- logic/pd_ctrl_pkg.sv ----
// Package for the power-down control pair: commands, states, timing counts
// Assumes a single 25 MHz clock shared by both ends
// Contract
// (R1) Enter power-down on CKE low with NOP
// (R2) Controller keeps CKE high during busy operations
// (R3) CKE may drop during activate, precharge, refresh
// (R4) Unlocked DLL entry needs DLL reset afterwards
// (R5) All banks closed gives precharge, else active
// (R6) Entry disables buffers except clock, ODT, CKE, reset
// (R7) Controller sends NOP through tCPDED window
// (R8) Receivers turn off after tCPDED from entry
// (R9) Precharge with A12 zero: DLL off, slow exit
// (R10) Slow exit waits tXPDLL for DLL commands
// (R11) DLL stays on in active or A12 one
// (R12) Controller holds CKE low, reset high, clock stable
// (R13) Reset during power-down goes straight to reset
// (R14) Controller holds CKE low at least tCKE
// (R15) Power-down never exceeds nine refresh intervals; the controller holds CKE low for PD_MAX plus 2 cycles
// (R16) Exit on CKE high with NOP; hold tCKE
// (R17) Controller waits tXP or tXPDLL after exit
// (R18) Refresh between exit and entry waits tXP
// (R19) Re-entry waits tXPDLL from registered exit
// (R20) Early entry after refresh: NOP until tRFC
// (R21) No second CKE low within tRFC window
// (R22) Controller timers are counters from clock period
`default_nettype none
package pd_ctrl_pkg;
   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 40000;       // 25 MHz
   localparam int T_CKE_NS      = 5;           // Least CKE pulse
   localparam int T_CPDED_NCK   = 1;           // Command pass delay, in clocks
   localparam int T_XP_NS       = 6;           // Exit to any command
   localparam int T_XPDLL_NS    = 24;          // Exit to DLL command
   localparam int T_RFC_NS      = 160;         // Refresh cycle time
   localparam int T_REFI_NS     = 7800;        // Refresh interval
   localparam int PD_MAX_REFI   = 9;           // Max power-down in intervals
   // Least times round up, longest round down
   localparam int CKE_CYC   = (T_CKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CPDED_CYC = T_CPDED_NCK;
   localparam int XP_CYC    = (T_XP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int XPDLL_CYC = (T_XPDLL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RFC_CYC   = (T_RFC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PDMAX_CYC = (PD_MAX_REFI * T_REFI_NS * 1000) / CLK_PERIOD_PS;
   localparam int CNT_W     = 16;              // Timer width
   // ----------------------------------------------------------------
   // Command encoding {cs_n, ras_n, cas_n, we_n}
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      CMD_DES = 4'h8,
      CMD_NOP = 4'h7,
      CMD_ACT = 4'h3,
      CMD_PRE = 4'h2,
      CMD_REF = 4'h1,
      CMD_MRS = 4'h0,
      CMD_RD  = 4'h5,
      CMD_WR  = 4'h4
   } cmd_e;
   // Device power state, one-hot
   typedef enum logic [4:0] {
      DS_RESET = 5'h01,
      DS_IDLE  = 5'h02,
      DS_ENTER = 5'h04,
      DS_PDOWN = 5'h08,
      DS_EXIT  = 5'h10
   } dev_state_e;
   // Controller state, one-hot
   typedef enum logic [4:0] {
      CS_RUN   = 5'h01,
      CS_DROP  = 5'h02,
      CS_PD    = 5'h04,
      CS_RAISE = 5'h08,
      CS_WAIT  = 5'h10
   } ctl_state_e;
endpackage

`default_nettype wire

// ---- logic/pd_device.sv ----
// Device end: power-down entry, exit, mode and buffer gating
// Assumes the controller keeps the link rules on its side
`timescale 1ns/1ps
`default_nettype none
module pd_device (
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   pd_link_if.dev          link,
   input  wire logic [7:0] bankOpen,      // Banks open, one bit each
   input  wire logic       opBusy,        // Activate/precharge/refresh running
   input  wire logic       dllLocked,     // DLL lock from core
   input  wire logic       mrA12,         // Mode bit for precharge DLL
   output logic            inPowerDown,   // In power-down
   output logic            activePd,      // Active power-down mode
   output logic            prechargePd,   // Precharge power-down mode
   output logic            dllOn,         // DLL running
   output logic            cmdRxOn,       // Command receivers on
   output logic            ioBufOn,       // Data buffers on
   output logic            lowPower,      // Power-down current level reached
   output logic            needDllReset   // DLL reset required after exit
);
   import pd_ctrl_pkg::*;
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   dev_state_e state_ff;                  // Power state
   logic [CNT_W-1:0] cnt_ff;              // tCPDED counter
   logic unlockedEntry_ff;                // DLL unlocked at entry
   logic isNop;                           // NOP or deselect on bus
   assign isNop = (link.cmd == CMD_NOP) || (link.cmd == CMD_DES);

   // ----------------------------------------------------------------
   // Power state machine
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn || !link.resetN) begin   // Reset pin wins over power-down [R13]
         state_ff <= DS_RESET;
      end else begin
         case (state_ff)
            DS_RESET: state_ff <= DS_IDLE;
            DS_IDLE: begin
               if (!link.cke && isNop) begin   // Registered entry [R1]
                  state_ff <= DS_ENTER;
               end
            end
            DS_ENTER: begin                    // Wait out tCPDED [R8]
               if (link.cke && isNop) begin
                  state_ff <= DS_EXIT;
               end else if (cnt_ff >= CNT_W'(CPDED_CYC - 1)) begin
                  state_ff <= DS_PDOWN;
               end
            end
            DS_PDOWN: begin
               if (link.cke && isNop) begin    // Registered exit [R16]
                  state_ff <= DS_EXIT;
               end
            end
            DS_EXIT: state_ff <= DS_IDLE;
            default: state_ff <= DS_RESET;
         endcase
      end
   end

   // Counter for the entry window
   always_ff @(posedge sys_clk) begin
      if (!resetn || state_ff != DS_ENTER) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + CNT_W'(1);       // Counts tCPDED [R8]
      end
   end

   // Remember DLL lock at entry
   always_ff @(posedge sys_clk) begin
      if (!resetn || !link.resetN) begin
         unlockedEntry_ff <= 1'b0;
      end else if (state_ff == DS_IDLE && !link.cke && isNop) begin
         unlockedEntry_ff <= !dllLocked;       // Flags DLL reset need [R4]
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all registered
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         inPowerDown  <= 1'b0;
         activePd     <= 1'b0;
         prechargePd  <= 1'b0;
         dllOn        <= 1'b0;
         cmdRxOn      <= 1'b0;
         ioBufOn      <= 1'b0;
         lowPower     <= 1'b0;
         needDllReset <= 1'b0;
      end else begin
         inPowerDown  <= (state_ff == DS_ENTER) || (state_ff == DS_PDOWN);
         // Mode follows banks once operations finish [R5]
         activePd     <= (state_ff == DS_PDOWN) && !opBusy && (|bankOpen);
         prechargePd  <= (state_ff == DS_PDOWN) && !opBusy && !(|bankOpen);
         // DLL off in reset and in precharge power-down with A12 low [R9] [R11]
         dllOn        <= (state_ff != DS_RESET) &&
                         !((state_ff == DS_PDOWN) && !(|bankOpen) && !mrA12);
         // Receivers off only after tCPDED [R8] [R6]
         cmdRxOn      <= (state_ff != DS_PDOWN);
         ioBufOn      <= (state_ff != DS_PDOWN) && (state_ff != DS_ENTER); // [R6]
         // Current level only after running work ends [R3]
         lowPower     <= (state_ff == DS_PDOWN) && !opBusy;
         needDllReset <= unlockedEntry_ff && (state_ff == DS_IDLE);
      end
   end
endmodule // pd_device
`default_nettype wire

// ---- logic/pd_link_if.sv ----
// Interface carrying clock-enable, reset and command between both ends
// Assumes both ends run on sys_clk
`timescale 1ns/1ps
`default_nettype none
interface pd_link_if;
   import pd_ctrl_pkg::*;
   logic cke;        // Clock enable
   logic resetN;     // Memory reset, active low
   cmd_e cmd;        // Command bus
   logic odt;        // Termination request
   modport ctl (output cke, output resetN, output cmd, output odt);
   modport dev (input cke, input resetN, input cmd, input odt);
endinterface // pd_link_if
`default_nettype wire

// ---- verification/pd_link_sva.sv ----
// Checker on the link joining the power-down controller and device
// Assumes tb instantiates it beside the link interface, one clock
`timescale 1ns/1ps
`default_nettype none
module pd_link_sva #(
   parameter int PD_MAX = pd_ctrl_pkg::PDMAX_CYC   // Power-down limit, cycles
) (
   input wire logic              sys_clk,
   input wire logic              resetn,
   input wire logic              cke,
   input wire logic              resetN,
   input wire pd_ctrl_pkg::cmd_e cmd,
   input wire logic              odt
);
   import pd_ctrl_pkg::*;
   // ------------------------------------------------------------
   // Helpers and assertions
   // ------------------------------------------------------------
   logic        isNop;                     // NOP or deselect on bus
   logic [15:0] lowCnt_ff;                 // Cycles with CKE low
   assign isNop = (cmd == CMD_NOP) || (cmd == CMD_DES);
   // Count power-down length, cleared by reset or CKE high
   always_ff @(posedge sys_clk) begin
      if (!resetn || !resetN || cke) begin
         lowCnt_ff <= 16'h0000;
      end else begin
         lowCnt_ff <= lowCnt_ff + 16'h0001;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn || !resetN);
   a_fall_nop: assert property ($fell(cke) |-> isNop)
      else $error("command beside falling cke");
   a_cpded_nop: assert property ($fell(cke) |=> isNop)
      else $error("command inside pass delay");
   a_low_min: assert property ($fell(cke) |-> !cke [*2])
      else $error("cke low too short");
   a_exit_nop: assert property ($rose(cke) |-> isNop)
      else $error("command beside rising cke");
   a_exit_hold: assert property ($rose(cke) |-> cke [*2])
      else $error("cke high too short");
   a_ref_quiet: assert property (cmd == CMD_REF |=> isNop [*3])
      else $error("command inside refresh cycle");
   a_ref_one_low: assert property (cmd == CMD_REF |=>
      not (##[0:2] $fell(cke) ##[1:2] $fell(cke)))
      else $error("cke low twice after refresh");
   // Slack covers the entry and exit phases around the limit
   a_pd_limit: assert property (lowCnt_ff <= PD_MAX + 4)
      else $error("power-down held too long");
   a_odt_low: assert property (!cke |-> !odt)
      else $error("odt raised in power-down");
endmodule // pd_link_sva
`default_nettype wire

// ---- verification/tb.sv ----
// Testbench joining controller and device through the link
// Assumes a 25 MHz clock and a shortened power-down limit
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pd_ctrl_pkg::*;
   // ------------------------------------------------------------
   // Clock, stimulus, instances
   // ------------------------------------------------------------
   localparam int PD_SIM = 50;           // Short limit for simulation
   logic       sys_clk = 1'b0;           // 40 ns clock
   logic       resetn = 1'b0;            // Sync reset, low active
   logic       pdReq = 1'b0, busy = 1'b0, refReq = 1'b0;
   logic       slowExit = 1'b0, memReset = 1'b0, opBusy = 1'b0;
   logic       dllLocked = 1'b1, mrA12 = 1'b0;
   logic [7:0] bankOpen = 8'h00;         // Open banks
   logic       pdActive, cmdReady, dllCmdReady, inPowerDown, activePd;
   logic       prechargePd, dllOn, cmdRxOn, ioBufOn, lowPower, needDllReset;
   int         failCount = 0, checks = 0, cycles = 0;
   always #20 sys_clk = ~sys_clk;
   pd_link_if link ();
   pd_controller #(.PD_MAX(PD_SIM)) pd_controller_i (.sys_clk(sys_clk),
      .resetn(resetn), .link(link.ctl), .pdReq(pdReq), .busy(busy),
      .refReq(refReq), .slowExit(slowExit), .memReset(memReset),
      .pdActive(pdActive), .cmdReady(cmdReady), .dllCmdReady(dllCmdReady));
   pd_device pd_device_i (.sys_clk(sys_clk), .resetn(resetn), .link(link.dev),
      .bankOpen(bankOpen), .opBusy(opBusy), .dllLocked(dllLocked), .mrA12(mrA12),
      .inPowerDown(inPowerDown), .activePd(activePd), .prechargePd(prechargePd),
      .dllOn(dllOn), .cmdRxOn(cmdRxOn), .ioBufOn(ioBufOn), .lowPower(lowPower),
      .needDllReset(needDllReset));
   pd_link_sva #(.PD_MAX(PD_SIM)) pd_link_sva_i (.sys_clk(sys_clk),
      .resetn(resetn), .cke(link.cke), .resetN(link.resetN), .cmd(link.cmd),
      .odt(link.odt));
   // Step past edges, drive just after
   task automatic tick(input int n = 1);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask
   // Compare and count
   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         failCount++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Bounded wait for power-down state
   task automatic waitPd(input logic lvl);
      int n;
      n = 0;
      while (inPowerDown !== lvl && n < 100) begin
         tick();
         n++;
      end
   endtask
   // One power-down mode: entry, state, exit
   task automatic t_mode(input logic [7:0] banks, input logic a12,
                         input logic locked, input logic act, input logic dll);
      bankOpen = banks;
      mrA12 = a12;
      dllLocked = locked;
      slowExit = !act && !a12;
      pdReq = 1'b1;
      waitPd(1'b1);
      check("cmdRxOn", {7'h00, cmdRxOn}, 8'h01);
      tick(3);
      check("activePd", {7'h00, activePd}, {7'h00, act});
      check("prechargePd", {7'h00, prechargePd}, {7'h00, !act});
      check("dllOn", {7'h00, dllOn}, {7'h00, dll});
      check("ioBufOn", {7'h00, ioBufOn}, 8'h00);
      check("cmdRxOn", {7'h00, cmdRxOn}, 8'h00);
      check("lowPower", {7'h00, lowPower}, 8'h01);
      check("pdActive", {7'h00, pdActive}, 8'h01);
      check("cmdReady", {7'h00, cmdReady}, 8'h00);
      pdReq = 1'b0;
      waitPd(1'b0);
      check("cmdReady", {7'h00, cmdReady}, 8'h00);
      tick(4);
      check("cmdReady", {7'h00, cmdReady}, 8'h01);
      check("pdActive", {7'h00, pdActive}, 8'h00);
      check("dllCmdReady", {7'h00, dllCmdReady}, 8'h01);
      check("needDllReset", {7'h00, needDllReset}, {7'h00, !locked});
      $display("test mode %h %b done", banks, a12);
   endtask
   // Busy blocks entry, operations delay low power
   task automatic t_busy();
      busy = 1'b1;
      opBusy = 1'b1;
      pdReq = 1'b1;
      tick(20);
      check("cke", {7'h00, link.cke}, 8'h01);
      busy = 1'b0;
      waitPd(1'b1);
      tick(3);
      check("lowPower", {7'h00, lowPower}, 8'h00);
      opBusy = 1'b0;
      tick(3);
      check("lowPower", {7'h00, lowPower}, 8'h01);
      pdReq = 1'b0;
      waitPd(1'b0);
      tick(6);
      $display("test busy done");
   endtask
   // Refresh then early entry, then memory reset in power-down
   task automatic t_ref_reset();
      int n;
      refReq = 1'b1;
      pdReq = 1'b1;
      n = 0;
      while (link.cmd !== CMD_REF && n < 30) begin
         tick();
         n++;
      end
      refReq = 1'b0;
      check("cmd", {4'h0, link.cmd}, {4'h0, CMD_REF});
      waitPd(1'b1);
      pdReq = 1'b0;
      waitPd(1'b0);
      tick(6);
      pdReq = 1'b1;
      waitPd(1'b1);
      memReset = 1'b1;
      tick(3);
      check("inPowerDown", {7'h00, inPowerDown}, 8'h00);
      check("resetN", {7'h00, link.resetN}, 8'h00);
      memReset = 1'b0;
      pdReq = 1'b0;
      tick(20);
      $display("test refresh reset done");
   endtask
   // Held request ends at the duration limit
   task automatic t_limit();
      pdReq = 1'b1;
      waitPd(1'b1);
      waitPd(1'b0);
      pdReq = 1'b0;
      check("inPowerDown", {7'h00, inPowerDown}, 8'h00);
      tick(6);
      $display("test limit done");
   endtask
   // Print counts and verdict, end run
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, failCount);
      if (failCount == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         failCount++;
         summarize();
      end
   end
   // Main sequence
   initial begin
      tick(10);
      resetn = 1'b1;
      tick(2);
      t_mode(8'h00, 1'b0, 1'b1, 1'b0, 1'b0);
      t_mode(8'h00, 1'b1, 1'b1, 1'b0, 1'b1);
      t_mode(8'h04, 1'b0, 1'b0, 1'b1, 1'b1);
      t_busy();
      t_ref_reset();
      t_limit();
      summarize();
   end
endmodule // tb
`default_nettype wire
